/* File: hw/qbt_pkg.sv */
// Package of widths and constants for the quad bus transceiver with parity
package qbt_pkg;
    // ---------------------------------------------------------------
    // Widths
    // ---------------------------------------------------------------
    localparam int QBT_WIDTH = 4;                  // Lanes per transceiver
    typedef logic [QBT_WIDTH-1:0] qbt_nib_t;       // One nibble of lanes
    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam qbt_nib_t QBT_DRV_RST = 4'h0;       // Driver register after reset
    localparam qbt_nib_t QBT_LATCH_RST = 4'h0;     // Receive latch after reset
    // ---------------------------------------------------------------
    // Parity helper used by generate and check paths
    // ---------------------------------------------------------------
    // Odd parity flag: high when the nibble holds an even number of ones
    function automatic logic qbt_odd_parity(input qbt_nib_t d);
        qbt_odd_parity = ~(^d);
    endfunction : qbt_odd_parity
endpackage : qbt_pkg

/* File: hw/qbt_lane.sv */
// One bus lane: inverting driver, inverting receiver and receive latch
module qbt_lane
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic drv_bit,
    input wire logic bus_drive_disable,
    input wire logic receive_hold,
    input wire logic bus_in,
    output logic bus_out,
    output logic bus_en,
    output logic rx_bit
);
    import qbt_pkg::*;

    logic rx_reg;   // Latched receive level
    logic rx_next;  // Next latched level

    // ---------------------------------------------------------------
    // Driver path
    // ---------------------------------------------------------------
    // Bus sees the inverse of the register bit
    assign bus_out = ~drv_bit; // [R3]

    // Lane drives only while the disable input is low
    assign bus_en = ~bus_drive_disable; // [R4]

    // ---------------------------------------------------------------
    // Receive latch
    // ---------------------------------------------------------------
    // Open latch follows inverted bus, closed latch keeps its value
    always_comb
    begin
        rx_next = rx_reg;
        if (!receive_hold)
        begin
            rx_next = ~bus_in; // [R5] [R6]
        end
    end

    // Registers the latch state
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            rx_reg <= QBT_LATCH_RST[0];
        end
        else
        begin
            rx_reg <= rx_next; // [R7]
        end
    end

    assign rx_bit = rx_reg;
endmodule : qbt_lane

/* File: hw/qbt_top.sv */
// Quad three-state bus transceiver with odd parity generate and check
// How it works
// [R1] Driver register loads data only on driver clock
// [R2] Load happens on driver clock rising edge
// [R3] Enabled bus drivers output inverted register bits
// [R4] Disable high: drivers float, device receives bus
// [R5] Receivers invert bus, end to end non-inverted
// [R6] Receive hold low: latches follow bus lines
// [R7] Receive hold high: latches keep stored data
// [R8] Output disable high floats receiver outputs
// [R9] Drivers enabled: parity generated from driver data
// [R10] Drivers floating: parity checks latched receive data
// [R11] Only one agent drives the bus at once
module qbt_top
(
    input wire logic clk,
    input wire logic reset_n,
    input wire qbt_pkg::qbt_nib_t drv_data,
    input wire logic driver_clock,
    input wire logic bus_drive_disable,
    input wire logic receive_hold,
    input wire logic rx_out_disable,
    input wire qbt_pkg::qbt_nib_t bus_in,
    output qbt_pkg::qbt_nib_t bus_out,
    output qbt_pkg::qbt_nib_t bus_oe,
    output qbt_pkg::qbt_nib_t rx_out,
    output qbt_pkg::qbt_nib_t rx_oe,
    output logic parity_out
);
    import qbt_pkg::*;

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    qbt_nib_t drv_reg;          // Driver register
    qbt_nib_t drv_next;         // Next driver register value
    logic dclk_reg;             // Previous driver clock sample
    qbt_nib_t lane_bus;         // Inverted driver bits per lane
    qbt_nib_t lane_oe;          // Drive enable per lane
    qbt_nib_t lane_rx;          // Latched receive bits per lane
    qbt_nib_t bus_out_next;     // Next bus data
    qbt_nib_t bus_oe_next;      // Next bus enables
    qbt_nib_t rx_out_next;      // Next receiver outputs
    qbt_nib_t rx_oe_next;       // Next receiver enables
    logic parity_next;          // Next parity flag
    qbt_nib_t bus_out_reg;      // Registered bus data
    qbt_nib_t bus_oe_reg;       // Registered bus enables
    qbt_nib_t rx_out_reg;       // Registered receiver outputs
    qbt_nib_t rx_oe_reg;        // Registered receiver enables
    logic parity_reg;           // Registered parity flag

    // ---------------------------------------------------------------
    // Driver register
    // ---------------------------------------------------------------
    // Load on a rising driver clock, otherwise hold
    always_comb
    begin
        drv_next = drv_reg; // [R1]
        if (driver_clock && !dclk_reg)
        begin
            drv_next = drv_data; // [R2]
        end
    end

    // Registers the driver register and clock history
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            drv_reg <= QBT_DRV_RST;
            dclk_reg <= 1'b0;
        end
        else
        begin
            drv_reg <= drv_next;
            dclk_reg <= driver_clock;
        end
    end

    // ---------------------------------------------------------------
    // Lanes
    // ---------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < QBT_WIDTH; gi++)
        begin : g_lane
            qbt_lane u_lane (
                .clk(clk),
                .reset_n(reset_n),
                .drv_bit(drv_reg[gi]),
                .bus_drive_disable(bus_drive_disable),
                .receive_hold(receive_hold),
                .bus_in(bus_in[gi]),
                .bus_out(lane_bus[gi]),
                .bus_en(lane_oe[gi]),
                .rx_bit(lane_rx[gi])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // Output stage
    // ---------------------------------------------------------------
    // Computes bus, receiver and parity outputs
    always_comb
    begin
        bus_out_next = lane_bus; // [R3]
        // Drivers float while disabled; partner keeps a single driver
        bus_oe_next = lane_oe; // [R4]
        rx_out_next = lane_rx;
        rx_oe_next = rx_out_disable ? 4'h0 : 4'hf; // [R8]
        if (!bus_drive_disable)
        begin
            parity_next = qbt_odd_parity(drv_reg); // [R9]
        end
        else
        begin
            parity_next = qbt_odd_parity(lane_rx); // [R10]
        end
    end

    // Registers all outputs
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            bus_out_reg <= 4'h0;
            bus_oe_reg <= 4'h0;
            rx_out_reg <= QBT_LATCH_RST;
            rx_oe_reg <= 4'h0;
            parity_reg <= 1'b0;
        end
        else
        begin
            bus_out_reg <= bus_out_next;
            bus_oe_reg <= bus_oe_next;
            rx_out_reg <= rx_out_next;
            rx_oe_reg <= rx_oe_next;
            parity_reg <= parity_next;
        end
    end

    assign bus_out = bus_out_reg;
    assign bus_oe = bus_oe_reg;
    assign rx_out = rx_out_reg;
    assign rx_oe = rx_oe_reg;
    assign parity_out = parity_reg;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    a_drv_load_edge: assert property (@(posedge clk) disable iff (!reset_n) // [R2]
        (driver_clock && !dclk_reg) |=> (drv_reg == $past(drv_data)))
        else $error("driver register missed load on rising driver clock");
    a_drv_hold_value: assert property (@(posedge clk) disable iff (!reset_n) // [R1]
        !(driver_clock && !dclk_reg) |=> $stable(drv_reg))
        else $error("driver register changed without driver clock edge");
    a_bus_inverted_data: assert property (@(posedge clk) disable iff (!reset_n) // [R3]
        (driver_clock && !dclk_reg) |=> ##2 (bus_out == ~$past(drv_data, 3)))
        else $error("bus data not inverse of loaded driver data");
    a_bus_float_disable: assert property (@(posedge clk) disable iff (!reset_n) // [R4]
        bus_drive_disable |=> (bus_oe == 4'h0))
        else $error("bus driven while disabled");
    a_rx_follow_bus: assert property (@(posedge clk) disable iff (!reset_n) // [R6]
        !receive_hold |=> ##1 (rx_out == ~$past(bus_in, 2)))
        else $error("open latch did not follow inverted bus");
    a_rx_hold_data: assert property (@(posedge clk) disable iff (!reset_n) // [R7]
        (receive_hold && $past(receive_hold)) |=> $stable(rx_out))
        else $error("closed latch output changed");
    a_rx_float_disable: assert property (@(posedge clk) disable iff (!reset_n) // [R8]
        rx_out_disable |=> (rx_oe == 4'h0))
        else $error("receiver outputs driven while disabled");
    a_par_gen_mode: assert property (@(posedge clk) disable iff (!reset_n) // [R9]
        !bus_drive_disable |=> (parity_out == ~(^$past(drv_reg))))
        else $error("generated parity wrong");
    a_par_chk_mode: assert property (@(posedge clk) disable iff (!reset_n) // [R10]
        bus_drive_disable |=> (parity_out == ~(^$past(lane_rx))))
        else $error("checked parity wrong");
    c_drive_bus: cover property (@(posedge clk) disable iff (!reset_n)
        !bus_drive_disable ##1 (bus_oe == 4'hf));
    c_receive_open: cover property (@(posedge clk) disable iff (!reset_n)
        bus_drive_disable && !receive_hold && !rx_out_disable);
    c_latch_closed: cover property (@(posedge clk) disable iff (!reset_n)
        receive_hold [*3]);
    c_load_edge: cover property (@(posedge clk) disable iff (!reset_n)
        driver_clock && !dclk_reg);
endmodule : qbt_top

/* File: tb/qbt_bus_agent.sv */
// Far-side bus agent with pull-ups that shares the four bus lines
module qbt_bus_agent
    import qbt_pkg::*;
(
    input wire qbt_pkg::qbt_nib_t bus_out,
    input wire qbt_pkg::qbt_nib_t bus_oe,
    input wire logic agent_en,
    input wire qbt_pkg::qbt_nib_t agent_data,
    output qbt_pkg::qbt_nib_t bus_level
);
    // ------------------------------------------------------------
    // Line resolution
    // ------------------------------------------------------------
    // Agent drives a lane only while the transceiver floats it
    always_comb
    begin
        for (int i = 0; i < QBT_WIDTH; i++)
        begin
            if (bus_oe[i])
                bus_level[i] = bus_out[i];
            else if (agent_en)
                bus_level[i] = agent_data[i];
            else
                bus_level[i] = 1'b1; // Pull-up holds idle lane high
        end
    end
endmodule : qbt_bus_agent

/* File: tb/qbt_top_tb.sv */
// Self-checking bench for the quad bus transceiver
module qbt_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import qbt_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    typedef struct packed {
        qbt_nib_t bus_out;
        logic bus_oe;
        qbt_nib_t rx_out;
        logic rx_oe;
        logic par;
    } qbt_note_s;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    qbt_nib_t drv_data = 4'h0;
    logic driver_clock = 1'b0;
    logic bus_drive_disable = 1'b0;
    logic receive_hold = 1'b0;
    logic rx_out_disable = 1'b0;
    logic agent_en = 1'b0;
    qbt_nib_t agent_data = 4'h0;
    qbt_nib_t bus_level, bus_out, bus_oe, rx_out, rx_oe, drv_m, rx_m, ag;
    logic parity_out;
    logic [31:0] seed = 32'hd856;
    int bad_count = 0;
    int checked = 0;
    qbt_note_s notes[$]; // Expected results, oldest first
    event look;
    always #5 clk = ~clk;
    qbt_top u_dut (.clk(clk), .reset_n(reset_n), .drv_data(drv_data),
        .driver_clock(driver_clock), .bus_drive_disable(bus_drive_disable),
        .receive_hold(receive_hold), .rx_out_disable(rx_out_disable), .bus_in(bus_level),
        .bus_out(bus_out), .bus_oe(bus_oe), .rx_out(rx_out), .rx_oe(rx_oe),
        .parity_out(parity_out));
    qbt_bus_agent u_agent (.bus_out(bus_out), .bus_oe(bus_oe), .agent_en(agent_en),
        .agent_data(agent_data), .bus_level(bus_level));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Next random nibble from the shift register
    function automatic qbt_nib_t rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[3:0];
    endfunction : rnd
    task automatic cmp_nib(input string what, input qbt_nib_t exp, input qbt_nib_t got);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_nib
    task automatic cmp_bit(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask : cmp_bit
    task automatic complete_run();
        if (bad_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    // One settled step; c = {disable, hold, rx off, agent on, clock pulse}
    task automatic step(input qbt_nib_t d, input logic [4:0] c, input qbt_nib_t a);
        qbt_note_s n;
        qbt_nib_t bus_m;
        @(posedge clk);
        #1;
        driver_clock = 1'b0;
        drv_data = d;
        {bus_drive_disable, receive_hold, rx_out_disable, agent_en} = c[4:1];
        agent_data = a;
        @(posedge clk);
        #1;
        driver_clock = c[0];
        repeat (6) @(posedge clk);
        #1;
        if (c[0])
            drv_m = d;
        bus_m = c[4] ? (c[1] ? a : 4'hf) : ~drv_m;
        if (!c[3])
            rx_m = ~bus_m;
        n = '{~drv_m, ~c[4], rx_m, ~c[2], c[4] ? ~(^rx_m) : ~(^drv_m)};
        notes.push_back(n);
        ->look;
    endtask : step
    // ------------------------------------------------------------
    // Output watcher
    // ------------------------------------------------------------
    initial
    begin
        qbt_note_s n;
        forever
        begin
            @(look);
            n = notes.pop_front();
            if (n.bus_oe)
                cmp_nib("bus_out", n.bus_out, bus_out);
            cmp_nib("bus_oe", {4{n.bus_oe}}, bus_oe);
            if (n.rx_oe)
                cmp_nib("rx_out", n.rx_out, rx_out);
            cmp_nib("rx_oe", {4{n.rx_oe}}, rx_oe);
            cmp_bit("parity_out", n.par, parity_out);
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        drv_m = QBT_DRV_RST;
        rx_m = QBT_LATCH_RST;
        repeat (20) @(posedge clk);
        #1;
        // Outputs idle while held in reset
        notes.push_back('0);
        ->look;
        reset_n = 1'b1;
        for (int i = 0; i < 8; i++)
            step(rnd(), 5'b00001, 4'h0);
        step(rnd(), 5'b00000, 4'h0);
        for (int i = 0; i < 6; i++)
        begin
            ag = rnd();
            step(rnd(), 5'b10010, ag);
            step(rnd(), 5'b11011, ~ag);
            step(rnd(), 5'b11100, ag);
        end
        // Mid-run reset clears register, latches and outputs
        @(posedge clk);
        #1;
        reset_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        drv_m = QBT_DRV_RST;
        rx_m = QBT_LATCH_RST;
        notes.push_back('0);
        ->look;
        reset_n = 1'b1;
        step(rnd(), 5'b10000, 4'h0);
        step(rnd(), 5'b00000, 4'h0);
        complete_run();
    end
    // Watchdog well past the few hundred cycles the steps take
    initial
    begin
        #50000;
        bad_count++;
        complete_run();
    end
endmodule : qbt_top_tb
